// File: src/dsc_compressor.sv
// Purpose: dictionary compressor for image strips, bytes in, packed codes out
// Assumes: source marks the final byte of each strip with last; strips hold at least one byte
// Notes:   string table is a 4096-slot open-addressed hash, cleared by a walk per strip
`timescale 1ns/1ns
`include "dsc_regs.svh"

// Overview of operation
// - each strip compressed alone; table walked clear before every strip
// - codes are variable width, never wider than twelve bits
// - input characters are whole bytes regardless of sample depth
// - after init every byte value is its own single-byte code
// - first code of each strip is the reset code 256
// - code 257 emitted once after the last data code of a strip
// - new strings get ascending codes from 258 after each init
// - first byte of a strip becomes the prefix with no code emitted
// - extended string found: it becomes the prefix, nothing emitted
// - extended string missing: emit prefix, add entry, prefix becomes new byte
// - width 9, then 10 after entry 511, 11 after 1023, 12 after 2047
// - once entry 4094 is used before the strip's last byte emit 12-bit reset code, reinit, back to 9 bits
// - codes packed msb first; each strip starts on a byte boundary
module dsc_compressor (
  input  wire logic                 i_clock,
  input  wire logic                 i_nrst,
  input  wire dsc_pkg::dsc_byte_type i_in,
  output logic                      o_in_ready,
  output dsc_pkg::dsc_byte_type     o_out,
  input  wire logic                 i_out_ready
);
  import dsc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] code_width(input logic [12:0] n);
    if (n >= `DSC_W12_FROM)      code_width = `DSC_WIDTH_12;
    else if (n >= `DSC_W11_FROM) code_width = `DSC_WIDTH_11;
    else if (n >= `DSC_W10_FROM) code_width = `DSC_WIDTH_10;
    else                         code_width = `DSC_WIDTH_9;
  endfunction

  function automatic logic [11:0] slot_hash(input logic [11:0] p, input logic [7:0] c);
    slot_hash = p ^ {c, 4'h0};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  dsc_slot_type  tab [0:4095];
  dsc_state_type st_q, st_d, ret_q, ret_d;
  logic [12:0]   nc_q, nc_d;
  logic [11:0]   prefix_q, prefix_d, probe_q, probe_d, walk_q, walk_d;
  logic [7:0]    chr_q, chr_d;
  logic          last_q, last_d, have_q, have_d, pad_q, pad_d, rdy_q, rdy_d;
  logic [23:0]   acc_q, acc_d;
  logic [11:0]   last_emit_q, last_emit_d;
  logic [4:0]    cnt_q, cnt_d;
  dsc_byte_type  out_q, out_d;
  logic          emit_en, we, hit;
  logic [11:0]   emit_code, waddr;
  logic [3:0]    emit_w;
  logic [4:0]    shift;
  dsc_slot_type  wdata, slot;

  assign slot = tab[probe_q];
  assign hit  = slot.valid && slot.prefix == prefix_q && slot.chr == chr_q;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d      = st_q;
    ret_d     = ret_q;
    nc_d      = nc_q;
    prefix_d  = prefix_q;
    probe_d   = probe_q;
    walk_d    = walk_q;
    chr_d     = chr_q;
    last_d    = last_q;
    have_d    = have_q;
    pad_d     = pad_q;
    acc_d     = acc_q;
    cnt_d     = cnt_q;
    out_d     = out_q;
    last_emit_d = last_emit_q;
    emit_en   = 1'b0;
    emit_code = 12'h000;
    emit_w    = code_width(nc_q);
    we        = 1'b0;
    waddr     = walk_q;
    wdata     = '0;
    shift     = 5'h00;
    if (i_out_ready) begin
      out_d.valid = 1'b0;
    end
    case (st_q)
      S_INIT: begin
        emit_en   = 1'b1;
        emit_code = `DSC_RESET_CODE;
        pad_d     = 1'b0;
        walk_d    = 12'h000;
        ret_d     = S_WALK;
        st_d      = S_DRAIN;
      end
      S_WALK: begin
        we     = 1'b1;
        walk_d = walk_q + 12'h001;
        if (walk_q == `DSC_SLOT_LAST) begin
          nc_d = `DSC_FIRST_ENTRY;
          st_d = S_READ;
        end
      end
      S_READ: begin
        if (i_in.valid && rdy_q) begin
          if (!have_q) begin
            prefix_d = {4'h0, i_in.data};
            have_d   = 1'b1;
            st_d     = i_in.last ? S_FL1 : S_READ;
          end else begin
            chr_d   = i_in.data;
            last_d  = i_in.last;
            probe_d = slot_hash(prefix_q, i_in.data);
            st_d    = S_PROBE;
          end
        end
      end
      S_PROBE: begin
        if (hit) begin
          prefix_d = slot.code;
          st_d     = last_q ? S_FL1 : S_READ;
        end else if (!slot.valid) begin
          emit_en   = 1'b1;
          emit_code = prefix_q;
          we        = 1'b1;
          waddr     = probe_q;
          wdata     = '{valid: 1'b1, prefix: prefix_q, chr: chr_q, code: nc_q[11:0]};
          nc_d      = nc_q + 13'h0001;
          prefix_d  = {4'h0, chr_q};
          st_d      = S_DRAIN;
          if (last_q)                          ret_d = S_FL1;
          else if (nc_q == `DSC_LAST_ENTRY)    ret_d = S_INIT;
          else                                 ret_d = S_READ;
        end else begin
          probe_d = probe_q + 12'h001;
        end
      end
      S_FL1: begin
        emit_en   = 1'b1;
        emit_code = prefix_q;
        nc_d      = nc_q + 13'h0001; // the flushed code still counts toward width
        ret_d     = S_FL2;
        st_d      = S_DRAIN;
      end
      S_FL2: begin
        emit_en   = 1'b1;
        emit_code = `DSC_EOS_CODE;
        nc_d      = `DSC_FIRST_ENTRY;
        have_d    = 1'b0;
        pad_d     = 1'b1;
        ret_d     = S_INIT;
        st_d      = S_DRAIN;
      end
      S_DRAIN: begin
        if (!out_q.valid || i_out_ready) begin
          if (cnt_q >= 5'h08 || (pad_q && cnt_q != 5'h00)) begin
            out_d = '{valid: 1'b1, data: acc_q[23:16], last: pad_q && cnt_q <= 5'h08};
            acc_d = {acc_q[15:0], 8'h00};
            cnt_d = (cnt_q >= 5'h08) ? cnt_q - 5'h08 : 5'h00;
          end else begin
            st_d = ret_q;
          end
        end
      end
      default: st_d = S_INIT;
    endcase
    if (emit_en) begin
      // acc holds under 8 bits here, so 24 bits always fit one more code
      shift = 5'(`DSC_ACC_BITS) - cnt_q - {1'b0, emit_w};
      acc_d = acc_q | ({12'h000, emit_code} << shift);
      cnt_d = cnt_q + {1'b0, emit_w};
      last_emit_d = emit_code;
    end
    rdy_d = (st_d == S_READ);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (we) begin
      tab[waddr] <= wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_q     <= S_INIT;
      ret_q    <= S_INIT;
      nc_q     <= `DSC_FIRST_ENTRY;
      prefix_q <= 12'h000;
      probe_q  <= 12'h000;
      walk_q   <= 12'h000;
      chr_q    <= 8'h00;
      last_q   <= 1'b0;
      have_q   <= 1'b0;
      pad_q    <= 1'b0;
      rdy_q    <= 1'b0;
      acc_q    <= 24'h000000;
      cnt_q    <= 5'h00;
      out_q    <= '0;
      last_emit_q <= 12'h000;
    end else begin
      st_q     <= st_d;
      ret_q    <= ret_d;
      nc_q     <= nc_d;
      prefix_q <= prefix_d;
      probe_q  <= probe_d;
      walk_q   <= walk_d;
      chr_q    <= chr_d;
      last_q   <= last_d;
      have_q   <= have_d;
      pad_q    <= pad_d;
      rdy_q    <= rdy_d;
      acc_q    <= acc_d;
      cnt_q    <= cnt_d;
      out_q    <= out_d;
      last_emit_q <= last_emit_d;
    end
  end

  assign o_in_ready = rdy_q;
  assign o_out      = out_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  chk_width_bound: assert property (emit_en |-> emit_w <= `DSC_WIDTH_12 && emit_w >= `DSC_WIDTH_9)
    else $error("code width out of range");
  chk_reset_first: assert property (st_q == S_WALK |-> last_emit_q == `DSC_RESET_CODE)
    else $error("table walk not preceded by reset code");
  chk_eos_after: assert property (st_q == S_FL2 |-> emit_code == `DSC_EOS_CODE && ret_q == S_FL2)
    else $error("end code not after pending prefix");
  chk_first_entry: assert property (st_q == S_WALK && walk_q == `DSC_SLOT_LAST |=> nc_q == `DSC_FIRST_ENTRY)
    else $error("entry counter not restarted");
  chk_first_byte: assert property (st_q == S_READ && i_in.valid && rdy_q && !have_q
                                   |-> !emit_en ##1 prefix_q == {4'h0, $past(i_in.data)})
    else $error("first byte not taken as prefix");
  chk_hit_silent: assert property (st_q == S_PROBE && hit |-> !emit_en ##1 prefix_q == $past(slot.code))
    else $error("hit emitted a code");
  chk_miss_emit: assert property (st_q == S_PROBE && !hit && !slot.valid
                                  |-> emit_code == prefix_q ##1 prefix_q == {4'h0, chr_q})
    else $error("miss did not emit prefix");
  chk_width_ten: assert property (emit_en && nc_q == `DSC_W10_FROM |-> emit_w == `DSC_WIDTH_10)
    else $error("width not grown after entry 511");
  chk_full_reset: assert property (st_q == S_PROBE && !hit && !slot.valid && !last_q && nc_q == `DSC_LAST_ENTRY
                                   |-> ##[1:8] (st_q == S_INIT && emit_w == `DSC_WIDTH_12))
    else $error("no 12-bit reset after entry 4094");
  chk_pad_end: assert property (st_q == S_DRAIN && pad_q && out_d.valid && out_d.last
                                |=> cnt_q == 5'h00 && o_out.valid && o_out.last)
    else $error("final byte leaves bits behind");

  cov_hit:    cover property (st_q == S_PROBE && hit);
  cov_full:   cover property (st_q == S_INIT && nc_q > `DSC_LAST_ENTRY);
  cov_strip:  cover property (o_out.valid && o_out.last && i_out_ready);
  cov_stall:  cover property (o_out.valid && !i_out_ready);

endmodule // dsc_compressor

// File: src/dsc_pkg.sv
// Purpose: types of the strip compressor
// Assumes: nothing
// Notes:   streams carry valid, byte and last together
package dsc_pkg;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } dsc_byte_type;

  typedef struct packed {
    logic        valid;
    logic [11:0] prefix;
    logic [7:0]  chr;
    logic [11:0] code;
  } dsc_slot_type;

  typedef enum logic [2:0] {
    S_INIT, S_WALK, S_READ, S_PROBE, S_DRAIN, S_FL1, S_FL2
  } dsc_state_type;

endpackage

// File: src/dsc_regs.svh
// Purpose: constants of the strip compressor
// Assumes: included by the compressor module only
// Notes:   codes are 12 bits wide at most, counters 13 bits
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

`define DSC_RESET_CODE   12'h100
`define DSC_EOS_CODE     12'h101
`define DSC_FIRST_ENTRY  13'h0102
`define DSC_LAST_ENTRY   13'h0FFE
`define DSC_W10_FROM     13'h0200
`define DSC_W11_FROM     13'h0400
`define DSC_W12_FROM     13'h0800
`define DSC_WIDTH_9      4'h9
`define DSC_WIDTH_10     4'hA
`define DSC_WIDTH_11     4'hB
`define DSC_WIDTH_12     4'hC
`define DSC_ACC_BITS     24
`define DSC_SLOT_LAST    12'hFFF

`endif

// File: testbench/dsc_sink_model.sv
// Purpose: code byte sink that stalls and records every byte it takes
// Assumes: one clock; a byte is taken on valid and ready at the edge
// Notes:   ready drops one cycle in three to stall the packer
`timescale 1ns/1ns
module dsc_sink_model (
  input  wire logic                  i_clock,
  input  wire logic                  i_nrst,
  input  wire dsc_pkg::dsc_byte_type i_out,
  output logic                       o_ready = 1'b0
);
  import dsc_pkg::*;
  logic [8:0] got[$];
  logic [1:0] phase_q = 2'h0;
  // ----------------
  // accept and stall
  // ----------------
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      phase_q <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      if (i_out.valid && o_ready)
        got.push_back({i_out.last, i_out.data});
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      o_ready <= (phase_q != 2'h1);
    end
  end
endmodule // dsc_sink_model

// File: testbench/tb_dsc_compressor.sv
// Purpose: self-checking bench of the strip compressor
// Assumes: sink model stalls; expected bytes come from a bench-side encoder
// Notes:   one long strip fills the table; its byte pairs never repeat, so every byte after the first adds an entry
`timescale 1ns/1ns
module tb_dsc_compressor;
  import dsc_pkg::*;
  logic         i_clock = 1'b0;
  logic         i_nrst = 1'b0;
  dsc_byte_type i_in = '0;
  logic         o_in_ready;
  dsc_byte_type o_out;
  logic         i_out_ready;
  int           bad_count = 0;
  int           comparisons = 0;
  int           seen = 0;
  logic [7:0]   src[$];
  logic [8:0]   exp_q[$];
  bit           bq[$];

  always #5 i_clock = ~i_clock;

  dsc_compressor dsc_compressor_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_in(i_in),
    .o_in_ready(o_in_ready), .o_out(o_out), .i_out_ready(i_out_ready));
  dsc_sink_model dsc_sink_model_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_out(o_out),
    .o_ready(i_out_ready));

  // -------------
  // checking core
  // -------------
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, got, want);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic put(input int code, input int w);
    for (int b = w - 1; b >= 0; b--)
      bq.push_back(code[b]);
  endtask

  function automatic int wid(input int n);
    return n < 512 ? 9 : n < 1024 ? 10 : n < 2048 ? 11 : 12;
  endfunction

  // encoder of the bench, fresh table per strip
  task automatic model();
    int dict[int];
    int nxt;
    int pre;
    int key;
    logic [8:0] v;
    nxt = 258;
    bq.delete();
    exp_q.delete();
    put(256, 9);
    pre = src[0];
    for (int i = 1; i < src.size(); i++) begin
      key = pre * 256 + src[i];
      if (dict.exists(key)) begin
        pre = dict[key];
      end else begin
        put(pre, wid(nxt));
        dict[key] = nxt;
        nxt++;
        pre = src[i];
        // table full mid-strip: 12-bit reset code, pending byte kept for later
        if (nxt == 4095 && i != src.size() - 1) begin
          put(256, 12);
          dict.delete();
          nxt = 258;
        end
      end
    end
    put(pre, wid(nxt));
    nxt++;
    put(257, wid(nxt));
    while (bq.size() % 8 != 0)
      bq.push_back(1'b0);
    for (int j = 0; j < bq.size(); j += 8) begin
      for (int b = 0; b < 8; b++)
        v[7 - b] = bq[j + b];
      v[8] = (j + 8 == bq.size());
      exp_q.push_back(v);
    end
  endtask

  task automatic run_strip();
    int k;
    model();
    for (int i = 0; i < src.size(); i++) begin
      i_in <= '{1'b1, src[i], i == src.size() - 1};
      k = 0;
      do begin
        @(negedge i_clock);
        k++;
      end while (o_in_ready !== 1'b1 && k < 20000);
      if (o_in_ready !== 1'b1)
        bad_count++;
      @(posedge i_clock);
    end
    i_in <= '{1'b0, ~src[src.size() - 1], 1'b0};
    k = 0;
    while (dsc_sink_model_inst.got.size() < seen + exp_q.size() && k < 20000) begin
      @(negedge i_clock);
      k++;
    end
    check(dsc_sink_model_inst.got.size(), seen + exp_q.size());
    for (int j = 0; j < exp_q.size(); j++)
      check(dsc_sink_model_inst.got[seen + j], exp_q[j]);
    seen = dsc_sink_model_inst.got.size();
  endtask

  // ---------
  // scenarios
  // ---------
  task automatic scn_example();
    src = '{8'h07, 8'h07, 8'h07, 8'h08, 8'h08, 8'h07, 8'h07, 8'h06, 8'h06};
    run_strip();
  endtask

  task automatic scn_single();
    src = '{8'hFF};
    run_strip();
  endtask

  task automatic scn_widths();
    src.delete();
    for (int i = 0; i < 600; i++)
      src.push_back(i[7:0]);
    run_strip();
  endtask

  // per low nibble, a walk through every pair of high nibbles; no pair repeats,
  // so every byte after the first misses and the table fills past entry 4094 mid-strip
  task automatic scn_table_full();
    src.delete();
    for (int g = 0; g < 16; g++) begin
      for (int a = 0; a < 16; a++) begin
        src.push_back({a[3:0], g[3:0]});
        for (int b = a + 1; b < 16; b++) begin
          src.push_back({a[3:0], g[3:0]});
          src.push_back({b[3:0], g[3:0]});
        end
      end
      src.push_back({4'h0, g[3:0]});
    end
    run_strip();
  endtask

  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    scn_example();
    scn_single();
    scn_example();
    scn_widths();
    scn_table_full();
    close_out();
  end

  // six table walks plus about five thousand bytes need well under this span
  initial begin
    #900000;
    bad_count++;
    close_out();
  end
endmodule // tb_dsc_compressor
